// ===== hw/aofc_regs.svh
// Register offsets, field positions, reset values and frame constants of the output framer.
`ifndef AOFC_REGS_SVH
`define AOFC_REGS_SVH
// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AOFC_OFS_RATE     8'h0D
`define AOFC_OFS_RSVD     8'h0E
`define AOFC_OFS_LANE1    8'h0F
`define AOFC_OFS_FRAME    8'h10
`define AOFC_OFS_PARITY   8'h11
// ----------------------------------------------------------------------------
// Field positions and reset value
// ----------------------------------------------------------------------------
`define AOFC_BIT_RATE     0
`define AOFC_BIT_STSCFG   0
`define AOFC_BIT_PATTERN  0
`define AOFC_FMT_LSB      4
`define AOFC_BIT_PAREN    2
`define AOFC_RESET_VAL    8'h00
// ----------------------------------------------------------------------------
// Frame constants
// ----------------------------------------------------------------------------
`define AOFC_PROTO_RETIME 2'h3
`define AOFC_FMT_RESULT   2'h0
`define AOFC_FMT_ID       2'h1
`define AOFC_FMT_FULL     2'h2
`define AOFC_TEST_WORD    16'hA5A5
`define AOFC_LEN_RESULT   6'h10
`define AOFC_LEN_ID       6'h14
`define AOFC_LEN_FULL     6'h1A
`endif

// ===== hw/aofc_pkg.sv
// Types shared by the output framer modules.
package aofc_pkg;
   typedef struct packed {
      logic [15:0] result;
      logic [3:0]  chan_id;
      logic [3:0]  dev_status;
      logic [1:0]  chan_cfg;
   } aofc_sample_t;

   typedef struct packed {
      logic [1:0] fmt;
      logic       pattern;
      logic       parity_en;
   } aofc_frame_cfg_t;

   typedef enum logic {
      AOFC_IDLE,
      AOFC_SHIFT
   } aofc_state_t;
endpackage

// ===== hw/aofc_frame_build.sv
// Frame composer: builds the left-aligned output frame and its length every cycle.
`timescale 1ns/10ps
`default_nettype none
`include "aofc_regs.svh"
module aofc_frame_build (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     nrst_i,
   // Frame sources
   input  wire aofc_pkg::aofc_sample_t   sample_i,
   input  wire aofc_pkg::aofc_frame_cfg_t cfg_i,
   // Composed frame
   output logic [31:0]                   frame_o,
   output logic [5:0]                    len_o
);
   wire         has_id   = (cfg_i.fmt == `AOFC_FMT_ID) || (cfg_i.fmt == `AOFC_FMT_FULL);
   wire         has_full = (cfg_i.fmt == `AOFC_FMT_FULL);
   wire [3:0]   id_part  = has_id ? sample_i.chan_id : 4'h0;
   wire [5:0]   st_part  = has_full ? {sample_i.dev_status, sample_i.chan_cfg} : 6'h00;
   // Reserved format value is treated as result only.
   wire [31:0]  body     = cfg_i.pattern ? {`AOFC_TEST_WORD, 16'h0000}
                                         : {sample_i.result, id_part, st_part, 6'h00};
   wire [5:0]   len_base = cfg_i.pattern ? `AOFC_LEN_RESULT
                         : has_full ? `AOFC_LEN_FULL
                         : has_id ? `AOFC_LEN_ID : `AOFC_LEN_RESULT;
   // Unused trailing bits are zero, so the reduction covers exactly the frame.
   wire         par_bit  = ^body; // see RULE_09 see RULE_17
   wire [5:0]   par_pos  = 6'h1F - len_base;
   wire [31:0]  par_word = ({31'h0, par_bit & cfg_i.parity_en}) << par_pos; // see RULE_10

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         frame_o <= 32'h0000_0000;
         len_o   <= 6'h00;
      end else begin
         frame_o <= body | par_word; // see RULE_05 see RULE_06 see RULE_07 see RULE_08
         len_o   <= len_base + {5'h00, cfg_i.parity_en}; // see RULE_10
      end
   end

   property p_len_result;
      @(posedge clk_i) disable iff (!nrst_i)
      (cfg_i.fmt == 2'h0 && !cfg_i.pattern && !cfg_i.parity_en) |=> (len_o == 6'h10);
   endproperty
   a_len_result: assert property (p_len_result) else $error("result-only frame length wrong"); // see RULE_05

   property p_len_full;
      @(posedge clk_i) disable iff (!nrst_i)
      (cfg_i.fmt == 2'h2 && !cfg_i.pattern && cfg_i.parity_en) |=> (len_o == 6'h1B);
   endproperty
   a_len_full: assert property (p_len_full) else $error("full frame with parity length wrong"); // see RULE_06

   property p_pattern;
      @(posedge clk_i) disable iff (!nrst_i)
      cfg_i.pattern |=> (frame_o[31:16] == 16'hA5A5 && frame_o[14:0] == 15'h0000);
   endproperty
   a_pattern: assert property (p_pattern) else $error("test pattern not on frame"); // see RULE_07

   property p_parity;
      @(posedge clk_i) disable iff (!nrst_i)
      (cfg_i.fmt == 2'h0 && !cfg_i.pattern && cfg_i.parity_en)
         |=> (frame_o[15] == ^$past(sample_i.result)) && (frame_o[31:16] == $past(sample_i.result));
   endproperty
   a_parity: assert property (p_parity) else $error("parity bit wrong"); // see RULE_09
endmodule
`default_nettype wire

// ===== hw/aofc_top.sv
// Output frame configuration registers and serial frame shifter.
`timescale 1ns/10ps
`default_nettype none
`include "aofc_regs.svh"
// Notes on behaviour
// RULE_01: Register writes are refused until the access-control unlock is given.
// RULE_02: The data-rate bit matters only when the output protocol select is 11b.
// RULE_03: With re-timed output, lanes shift once per clock period in SDR and on both edges in DDR.
// RULE_04: In one-lane mode lane 1 floats if its config bit is 0 and carries sequence status if 1.
// RULE_05: Frame format 00b is result only, 01b adds a 4-bit channel id, 11b is reserved.
// RULE_06: Frame format 10b adds channel id, 4-bit device status and 2-bit channel configuration.
// RULE_07: The test-pattern bit replaces the data with the fixed word A5A5.
// RULE_08: With the test-pattern bit clear the normal frame is shifted out.
// RULE_09: The parity bit is 1 when the frame holds an odd number of ones.
// RULE_10: Parity enable appends one bit, making the frame one bit longer.
// RULE_11: Reserved bits always read as zero.
// RULE_12: The host does not write reserved bits.
// RULE_13: The register at 0Eh has no function and reads zero.
// RULE_14: All registers of the group reset to zero.
// RULE_15: Protocol 11b uses the re-timer scheme, 00b follows the standard input SPI mode.
// RULE_16: With lane width 0 all data bits go out on lane 0.
// RULE_17: Parity covers every frame bit but not itself.
module aofc_top (
   // Clock and reset
   input  wire logic                   REF_CLK_I,
   input  wire logic                   NRST_I,
   // Register access from the command decoder
   input  wire logic                   REG_UNLOCK_I,
   input  wire logic                   REG_WR_I,
   input  wire logic                   REG_RD_I,
   input  wire logic [7:0]             REG_ADDR_I,
   input  wire logic [7:0]             REG_WDATA_I,
   output logic [7:0]                  REG_RDATA_O,
   // Neighbouring output settings
   input  wire logic [1:0]             OUTPUT_PROTOCOL_SELECT_I,
   input  wire logic                   OUTPUT_LANE_WIDTH_I,
   input  wire logic [1:0]             INPUT_SPI_MODE_I,
   // Conversion data
   input  wire aofc_pkg::aofc_sample_t SAMPLE_I,
   input  wire logic                   SEQUENCE_STATUS_PIN_I,
   // Serial link pins
   input  wire logic                   SCLK_I,
   input  wire logic                   CS_N_I,
   output logic                        SERIAL_OUT_LANE0_O,
   output logic                        SERIAL_OUT_LANE0_OE_N_O,
   output logic                        SERIAL_OUT_LANE1_O,
   output logic                        SERIAL_OUT_LANE1_OE_N_O
);
   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   logic        rate_ddr;
   logic        lane1_status_config;
   logic [1:0]  frame_fmt;
   logic        test_pattern_enable;
   logic        parity_en;

   wire wr_ok = REG_WR_I && REG_UNLOCK_I; // see RULE_01

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin // see RULE_14
         rate_ddr            <= 1'b0;
         lane1_status_config <= 1'b0;
         frame_fmt           <= 2'h0;
         test_pattern_enable <= 1'b0;
         parity_en           <= 1'b0;
      end else if (wr_ok) begin
         if (REG_ADDR_I == `AOFC_OFS_RATE) begin
            rate_ddr <= REG_WDATA_I[`AOFC_BIT_RATE];
         end
         if (REG_ADDR_I == `AOFC_OFS_LANE1) begin
            lane1_status_config <= REG_WDATA_I[`AOFC_BIT_STSCFG];
         end
         if (REG_ADDR_I == `AOFC_OFS_FRAME) begin
            frame_fmt           <= REG_WDATA_I[`AOFC_FMT_LSB +: 2];
            test_pattern_enable <= REG_WDATA_I[`AOFC_BIT_PATTERN];
         end
         if (REG_ADDR_I == `AOFC_OFS_PARITY) begin
            parity_en <= REG_WDATA_I[`AOFC_BIT_PAREN];
         end
      end
   end

   // Read mux; reserved bits and the 0Eh register are hard zero.
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = `AOFC_RESET_VAL; // see RULE_11 see RULE_13
      case (REG_ADDR_I)
         `AOFC_OFS_RATE:   rd_mux = {7'h00, rate_ddr};
         `AOFC_OFS_LANE1:  rd_mux = {7'h00, lane1_status_config};
         `AOFC_OFS_FRAME:  rd_mux = {2'h0, frame_fmt, 3'h0, test_pattern_enable};
         `AOFC_OFS_PARITY: rd_mux = {5'h00, parity_en, 2'h0};
         default:          rd_mux = `AOFC_RESET_VAL;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         REG_RDATA_O <= `AOFC_RESET_VAL;
      end else if (REG_RD_I) begin
         REG_RDATA_O <= rd_mux;
      end
   end

   // ----------------------------------------------------------------------------
   // Frame composer
   // ----------------------------------------------------------------------------
   aofc_pkg::aofc_frame_cfg_t fcfg;
   logic [31:0]               frame;
   logic [5:0]                frame_len;

   assign fcfg = '{fmt: frame_fmt, pattern: test_pattern_enable, parity_en: parity_en};

   aofc_frame_build u_build (
      .clk_i    (REF_CLK_I),
      .nrst_i   (NRST_I),
      .sample_i (SAMPLE_I),
      .cfg_i    (fcfg),
      .frame_o  (frame),
      .len_o    (frame_len)
   );

   // ----------------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------------------
   logic [1:0] sclk_sync;
   logic [1:0] cs_sync;
   logic       sclk_prev;
   logic       cs_prev;

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         sclk_sync <= 2'b00;
         cs_sync   <= 2'b11;
         sclk_prev <= 1'b0;
         cs_prev   <= 1'b1;
      end else begin
         sclk_sync <= {sclk_sync[0], SCLK_I};
         cs_sync   <= {cs_sync[0], CS_N_I};
         sclk_prev <= sclk_sync[1];
         cs_prev   <= cs_sync[1];
      end
   end

   wire sclk_rise = sclk_sync[1] && !sclk_prev;
   wire sclk_fall = !sclk_sync[1] && sclk_prev;
   wire cs_fall   = !cs_sync[1] && cs_prev;
   wire cs_high   = cs_sync[1];

   // ----------------------------------------------------------------------------
   // Shifter
   // ----------------------------------------------------------------------------
   wire retime    = (OUTPUT_PROTOCOL_SELECT_I == `AOFC_PROTO_RETIME); // see RULE_15
   wire ddr_on    = retime && rate_ddr; // see RULE_02
   // Standard SPI launches on the edge opposite to the one the host samples on.
   wire spi_rise  = INPUT_SPI_MODE_I[1] ^ INPUT_SPI_MODE_I[0];
   wire shift_evt = retime ? (sclk_rise || (ddr_on && sclk_fall)) // see RULE_03
                           : (spi_rise ? sclk_rise : sclk_fall);
   wire [5:0] step = OUTPUT_LANE_WIDTH_I ? 6'h02 : 6'h01; // see RULE_16

   aofc_pkg::aofc_state_t state;
   aofc_pkg::aofc_state_t next_state;
   logic [31:0]           shreg;
   logic [5:0]            remain;

   always_comb begin
      next_state = state;
      case (state)
         aofc_pkg::AOFC_IDLE:  if (cs_fall) next_state = aofc_pkg::AOFC_SHIFT;
         aofc_pkg::AOFC_SHIFT: if (cs_high) next_state = aofc_pkg::AOFC_IDLE;
         default:              next_state = aofc_pkg::AOFC_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state  <= aofc_pkg::AOFC_IDLE;
         shreg  <= 32'h0000_0000;
         remain <= 6'h00;
      end else begin
         state <= next_state;
         if (state == aofc_pkg::AOFC_IDLE && cs_fall) begin
            shreg  <= frame;
            remain <= frame_len;
         end else if (state == aofc_pkg::AOFC_SHIFT && shift_evt && remain != 6'h00) begin
            shreg  <= shreg << step;
            remain <= (remain > step) ? remain - step : 6'h00;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Output lanes (enable low means driven)
   // ----------------------------------------------------------------------------
   wire active = (state == aofc_pkg::AOFC_SHIFT);
   assign SERIAL_OUT_LANE0_O      = OUTPUT_LANE_WIDTH_I ? shreg[30] : shreg[31]; // see RULE_16
   assign SERIAL_OUT_LANE0_OE_N_O = !active;
   assign SERIAL_OUT_LANE1_O      = OUTPUT_LANE_WIDTH_I ? shreg[31] : SEQUENCE_STATUS_PIN_I;
   assign SERIAL_OUT_LANE1_OE_N_O = OUTPUT_LANE_WIDTH_I ? !active : !lane1_status_config; // see RULE_04

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_locked_write;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (REG_WR_I && !REG_UNLOCK_I) |=> $stable(frame_fmt) && $stable(parity_en) && $stable(rate_ddr);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write changed a register"); // see RULE_01

   // Outside the re-timer a set rate bit must not add shifts on the idle SPI edge.
   property p_rate_ignored;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (active && !retime && rate_ddr && !cs_high && (spi_rise ? sclk_fall : sclk_rise))
         |=> $stable(shreg);
   endproperty
   a_rate_ignored: assert property (p_rate_ignored) else $error("data rate applied outside re-timer"); // see RULE_02

   property p_sdr_fall;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (active && retime && !rate_ddr && sclk_fall && !cs_high) |=> $stable(shreg);
   endproperty
   a_sdr_fall: assert property (p_sdr_fall) else $error("SDR shifted on falling edge"); // see RULE_03

   property p_lane1_hiz;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (!OUTPUT_LANE_WIDTH_I && !lane1_status_config) |-> SERIAL_OUT_LANE1_OE_N_O;
   endproperty
   a_lane1_hiz: assert property (p_lane1_hiz) else $error("lane 1 driven while it should float"); // see RULE_04

   property p_rsvd_read;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (REG_RD_I && REG_ADDR_I == 8'h0E) |=> (REG_RDATA_O == 8'h00);
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved register read nonzero"); // see RULE_13

   property p_rsvd_bits;
      @(posedge REF_CLK_I) disable iff (!NRST_I)
      (REG_RD_I && REG_ADDR_I == 8'h10) |=> (REG_RDATA_O[7:6] == 2'h0 && REG_RDATA_O[3:1] == 3'h0);
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bits read nonzero"); // see RULE_11
endmodule
`default_nettype wire

// ===== tb/aofc_host.sv
// Host serial controller model: frames chip select and clock and captures the lane data.
`timescale 1ns/10ps
`default_nettype none
module aofc_host (
   // Link pins
   output logic        sclk_o,
   output logic        cs_n_o,
   input  wire logic   lane0_i,
   input  wire logic   lane1_i,
   // Captured frame
   output logic [31:0] word_o,
   output logic        done_o
);
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      word_o = 32'h0;
      done_o = 1'b0;
   end
   // The clock stands still outside frames; each bit is sampled just before the next edge.
   task automatic frame(input int nupd, input bit ddr, input bit two);
      done_o = 1'b0;
      word_o = 32'h0;
      cs_n_o = 1'b0;
      #800;
      for (int i = 0; i < nupd; i++) begin
         word_o = two ? {word_o[29:0], lane1_i, lane0_i} : {word_o[30:0], lane0_i};
         sclk_o = ~sclk_o;
         #400;
         if (!ddr) begin
            sclk_o = 1'b0;
            #400;
         end
      end
      cs_n_o = 1'b1;
      #400;
      sclk_o = 1'b0;
      #800;
      done_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== tb/test_aofc_top.sv
// Self-checking bench of the output framer: registers, lane behaviour and frame content.
`timescale 1ns/10ps
`default_nettype none
`include "aofc_regs.svh"
module test_aofc_top;
   logic                   clk, nrst, unlock, wr, rd, seq, sclk, cs_n, rd_dly, done;
   logic                   l0, l0_oe_n, l1, l1_oe_n, width;
   logic [7:0]             addr, wdata, rdata;
   logic [1:0]             proto, spi;
   logic [31:0]            word, rnd;
   aofc_pkg::aofc_sample_t sample;
   logic [31:0]            exp_q[$];
   int                     num_errors, n_tests;
   int                     seed = 58;
   localparam logic [7:0]  wv [5] = '{8'h01, 8'h00, 8'h01, 8'h31, 8'h04};

   aofc_top i_dut (
      .REF_CLK_I(clk), .NRST_I(nrst), .REG_UNLOCK_I(unlock), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
      .OUTPUT_PROTOCOL_SELECT_I(proto), .OUTPUT_LANE_WIDTH_I(width), .INPUT_SPI_MODE_I(spi),
      .SAMPLE_I(sample), .SEQUENCE_STATUS_PIN_I(seq), .SCLK_I(sclk), .CS_N_I(cs_n),
      .SERIAL_OUT_LANE0_O(l0), .SERIAL_OUT_LANE0_OE_N_O(l0_oe_n),
      .SERIAL_OUT_LANE1_O(l1), .SERIAL_OUT_LANE1_OE_N_O(l1_oe_n));

   aofc_host i_host (
      .sclk_o(sclk), .cs_n_o(cs_n), .lane0_i(l0), .lane1_i(l1), .word_o(word), .done_o(done));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("Mismatches %0d, checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Read data is compared one edge after the read strobe is taken; frames when captured.
   always @(posedge clk) begin
      rd_dly <= rd;
      if (rd_dly) check(rdata, exp_q.pop_front());
   end
   always @(posedge done) check(word, exp_q.pop_front());

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #10;
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(posedge clk);
      #10;
      wr = 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #10;
      addr = a;
      rd = 1'b1;
      exp_q.push_back({24'h0, e});
      @(posedge clk);
      #10;
      rd = 1'b0;
   endtask

   // One frame: program the rate, frame and parity registers, pick a random sample, note the expected bits, clock it out.
   task automatic run(input logic [1:0] p, input logic [1:0] m, input logic r, input logic w,
                      input logic [1:0] f, input logic t, input logic pe);
      int          n;
      logic [31:0] e;
      reg_wr(`AOFC_OFS_RATE, {7'h0, r});
      reg_wr(`AOFC_OFS_FRAME, {2'h0, f, 3'h0, t});
      reg_wr(`AOFC_OFS_PARITY, {5'h0, pe, 2'h0});
      proto = p;
      spi = m;
      width = w;
      rnd = $random(seed);
      sample = rnd[25:0];
      repeat (2) @(posedge clk);
      e = t ? 32'h0000A5A5 : {16'h0, sample.result};
      n = 16;
      if (!t && f != 2'h0) begin
         e = {e[27:0], sample.chan_id};
         n = 20;
      end
      if (!t && f == 2'h2) begin
         e = {e[25:0], sample.dev_status, sample.chan_cfg};
         n = 26;
      end
      if (pe) begin
         e = {e[30:0], ^e};
         n++;
      end
      exp_q.push_back(e);
      #10;
      i_host.frame(w ? n / 2 : n, p == 2'h3 && r, w);
   endtask

   initial begin
      {nrst, unlock, wr, rd, seq, width} = 6'h00;
      {addr, wdata, proto, spi} = 20'h0;
      sample = '0;
      repeat (12) @(posedge clk);
      #10;
      nrst = 1'b1;
      @(posedge clk);
      check(32'(l0_oe_n), 32'h1);
      check(32'(l1_oe_n), 32'h1);
      for (int i = 0; i < 6; i++) reg_rd(8'h0D + 8'(i), 8'h00);
      reg_wr(`AOFC_OFS_FRAME, 8'h31);
      reg_rd(`AOFC_OFS_FRAME, 8'h00);
      unlock = 1'b1;
      for (int i = 0; i < 5; i++) if (i != 1) reg_wr(8'h0D + 8'(i), wv[i]);
      for (int i = 0; i < 5; i++) reg_rd(8'h0D + 8'(i), wv[i]);
      for (int i = 0; i < 2; i++) begin
         rnd = $random(seed);
         seq = rnd[0] ^ i[0];
         repeat (2) @(posedge clk);
         check(32'(l1), 32'(seq));
         check(32'(l1_oe_n), 32'h0);
         #10;
      end
      run(2'h3, 2'h3, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0);
      run(2'h3, 2'h0, 1'b1, 1'b0, 2'h1, 1'b0, 1'b1);
      run(2'h0, 2'h1, 1'b1, 1'b0, 2'h2, 1'b0, 1'b1);
      run(2'h1, 2'h2, 1'b1, 1'b0, 2'h1, 1'b1, 1'b1);
      run(2'h3, 2'h0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b0);
      run(2'h0, 2'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1);
      close_out();
   end

   initial begin
      #1_000_000;
      num_errors++;
      close_out();
   end
endmodule
`default_nettype wire
